// *** design/hwcf_defs.vh ***
// Constants for the hardware configuration and receive FIFO level block.
//
// How it works
// R1: Discard control 1 drops errored received frames; 0 passes them on.
// R2: Transmit packs several frames per USB packet only while bit 5 is set.
// R3: USB receive side always accepts several frames per packet.
// R4: EEPROM time-out after 30 ms when bit 4 is 0, 1.28 us when 1.
// R5: Writing 1 to bit 3 starts lite reset; bit clears when sequence finishes.
// R6: Lite reset spares USB device controller, EEPROM reload and USB PHY connection.
// R7: Read-only bit 2 shows PHY in use: 0 internal, 1 external.
// R8: PHY-in-use indication resets to the level on the PHY choice pin.
// R9: Bit 1 set lets burst cap limit transmit bursts; clear leaves them unlimited.
// R10: Writing 1 to bit 0 starts full reset, resets external PHY, self-clears.
// R11: Full reset reloads EEPROM, holds USB PHY disconnected, then reconnects.
// R12: USB or lite reset restores drive boost to EEPROM image or 00b.
// R13: Bits 15:0 give receive FIFO bytes used, reset 0000h, dword rounded.
// R14: Self-clearing reset bits read 1 while their reset sequence runs.
`ifndef HWCF_DEFS_VH
`define HWCF_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define HWCF_ADDR_W          12
`define HWCF_OFS_HW_CFG      12'h0014
`define HWCF_OFS_RX_LEVEL    12'h0018

// ----------------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------------
`define HWCF_BIT_FULL_RST    0
`define HWCF_BIT_BURST_EN    1
`define HWCF_BIT_PHY_CHOICE_PIN     2
`define HWCF_BIT_LITE_RST    3
`define HWCF_BIT_EE_TMO      4
`define HWCF_BIT_MULTI       5
`define HWCF_BIT_DISCARD     6
`define HWCF_BOOST_LO        13
`define HWCF_BOOST_HI        14

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HWCF_RST_BOOST       2'h0
`define HWCF_RST_RX_LEVEL    16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HWCF_CLK_MHZ         50
`define HWCF_EE_LONG_NS      30000000
`define HWCF_EE_SHORT_NS     1280
`define HWCF_RST_HOLD_CYC    16

`endif

// *** design/hwcf_buf.v ***
// Two-entry valid/ready buffer for received frame descriptors.
`timescale 1ns/1ps
module hwcf_buf #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // Filling side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // Draining side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o,
  // Level
  output wire         full_o,
  output wire         empty_o
);

  reg [W-1:0] head_r;
  reg [W-1:0] tail_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;

  assign in_ready_o  = (cnt_r != 2'd2);
  assign out_valid_o = (cnt_r != 2'd0);
  assign out_data_o  = head_r;
  assign full_o      = (cnt_r == 2'd2);
  assign empty_o     = (cnt_r == 2'd0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // The head always holds the oldest word; the tail moves up on a pop.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 2'd0;
      head_r <= {W{1'b0}};
      tail_r <= {W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == 2'd0) head_r <= in_data_i;
          else tail_r <= in_data_i;
          cnt_r <= cnt_r + 2'd1;
        end
        2'b01: begin
          head_r <= tail_r;
          cnt_r  <= cnt_r - 2'd1;
        end
        2'b11: begin
          if (cnt_r == 2'd1) head_r <= in_data_i;
          else begin
            head_r <= tail_r;
            tail_r <= in_data_i;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

endmodule

// *** design/hwcf_top.v ***
// Hardware configuration register, reset sequencer and receive FIFO level.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "hwcf_defs.vh"
module hwcf_top #(
  parameter LEN_W       = 14,
  parameter CAP_W       = 8,
  parameter RST_CYC     = `HWCF_RST_HOLD_CYC,
  parameter EE_LONG_CYC = (`HWCF_EE_LONG_NS * `HWCF_CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input  wire                   clk_i,
  input  wire                   rst_i,
  // Wishbone slave
  input  wire                   cyc_i,
  input  wire                   stb_i,
  input  wire                   we_i,
  input  wire [`HWCF_ADDR_W-1:0] adr_i,
  input  wire [3:0]             sel_i,
  input  wire [31:0]            dat_i,
  output wire [31:0]            dat_o,
  output wire                   ack_o,
  // Straps, EEPROM image and USB events
  input  wire                   phy_choice_pin_i,
  input  wire                   eeprom_present_i,
  input  wire [1:0]             eeprom_boost_i,
  input  wire                   eeprom_load_done_i,
  input  wire                   usb_bus_reset_i,
  // EEPROM response timer
  input  wire                   ee_wait_i,
  output wire                   ee_timeout_o,
  // Received frame descriptors from the MAC
  input  wire                   rxd_valid_i,
  output wire                   rxd_ready_o,
  input  wire [LEN_W-1:0]       rxd_len_i,
  input  wire                   rxd_err_i,
  // Descriptors towards the receive FIFO writer
  output wire                   fifo_valid_o,
  input  wire                   fifo_ready_i,
  output wire [LEN_W-1:0]       fifo_len_o,
  // Receive FIFO drained by the USB receive side, one dword per pulse
  input  wire                   fifo_dword_read_i,
  // Transmit controls
  input  wire [CAP_W-1:0]       burst_cap_i,
  output wire [CAP_W-1:0]       tx_burst_limit_o,
  output wire                   tx_multi_frame_o,
  output wire                   usb_rx_multi_ok_o,
  // Reset controls
  output wire                   core_rst_o,
  output wire                   udc_rst_o,
  output wire                   ext_phy_rst_o,
  output wire                   usb_phy_detach_o,
  output wire                   eeprom_reload_o,
  output wire [1:0]             hs_drive_boost_o
);

  // --------------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------------
  // Limits round up, so a time-out never comes early.
  localparam EE_SHORT_CYC = (`HWCF_EE_SHORT_NS * `HWCF_CLK_MHZ + 999) / 1000;
  // TMO_W must hold EE_LONG_CYC and RC_W must hold RST_CYC.
  localparam TMO_W        = 22;
  localparam RC_W         = 8;

  // Idle, lite hold, full hold and EEPROM reload wait.
  localparam S_IDLE = 2'd0;
  localparam S_LITE = 2'd1;
  localparam S_FULL = 2'd2;
  localparam S_LOAD = 2'd3;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg             ack_r;
  reg  [31:0]     dat_r;
  reg             discard_r;
  reg             multi_r;
  reg             ee_tmo_sel_r;
  reg             burst_en_r;
  reg             phy_ext_r;
  reg             strap_pend_r;
  reg  [1:0]      boost_r;
  reg  [1:0]      st_r;
  reg  [1:0]      st_nxt;
  reg  [RC_W-1:0] rcnt_r;
  reg             reload_r;
  reg  [15:0]     level_r;
  reg  [15:0]     level_nxt;
  reg  [TMO_W-1:0] tmo_cnt_r;
  reg             tmo_r;
  reg  [CAP_W-1:0] limit_r;

  wire            wr_acc;
  wire            rd_acc;
  wire            hit_cfg;
  wire            hit_lvl;
  wire            lite_req;
  wire            full_req;
  wire            lite_busy;
  wire            full_busy;
  wire            seq_start;
  wire [31:0]     cfg_word;
  wire            in_valid;
  wire            in_ready;
  wire            in_push;
  wire            drop;
  wire [15:0]     rounded;
  wire [TMO_W-1:0] tmo_lim;

  // --------------------------------------------------------------------------
  // Wishbone decode
  // --------------------------------------------------------------------------
  // Every access is answered one cycle after the strobe; ack drops after one.
  // A write lands on the edge that sees ack high, as the master expects.
  // Unmapped offsets are acknowledged and read as zero.
  assign ack_o   = ack_r;
  assign dat_o   = dat_r;
  assign hit_cfg = (adr_i == `HWCF_OFS_HW_CFG);
  assign hit_lvl = (adr_i == `HWCF_OFS_RX_LEVEL);
  assign wr_acc  = cyc_i & stb_i & we_i & ack_r;
  assign rd_acc  = cyc_i & stb_i & ~we_i & ~ack_r;

  assign lite_busy = (st_r == S_LITE);
  assign full_busy = (st_r == S_FULL) | (st_r == S_LOAD);

  // Reset requests are ignored while a sequence is already running.
  assign lite_req  = wr_acc & hit_cfg & sel_i[0] & dat_i[`HWCF_BIT_LITE_RST] & (st_r == S_IDLE); // R5
  assign full_req  = wr_acc & hit_cfg & sel_i[0] & dat_i[`HWCF_BIT_FULL_RST] & (st_r == S_IDLE); // R10
  assign seq_start = lite_req | full_req;

  assign cfg_word = {17'h0_0000,
                     boost_r,
                     6'h00,
                     discard_r,
                     multi_r,
                     ee_tmo_sel_r,
                     lite_busy,  // R14
                     phy_ext_r,  // R7
                     burst_en_r,
                     full_busy}; // R14

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
      if (rd_acc) begin
        if (hit_cfg) dat_r <= cfg_word;
        else if (hit_lvl) dat_r <= {16'h0000, level_r}; // R13
        else dat_r <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration bits
  // --------------------------------------------------------------------------
  // A full or lite reset returns the controls to their defaults; the device
  // controller keeps running through a lite reset and is not touched here.
  // Byte lane 0 carries the controls; lane 1 carries the boost.
  always @(posedge clk_i) begin
    if (rst_i) begin
      discard_r    <= 1'b0;
      multi_r      <= 1'b0;
      ee_tmo_sel_r <= 1'b0;
      burst_en_r   <= 1'b0;
    end else if (full_req | lite_req) begin
      discard_r    <= 1'b0;
      multi_r      <= 1'b0;
      ee_tmo_sel_r <= 1'b0;
      burst_en_r   <= 1'b0;
    end else if (wr_acc & hit_cfg & sel_i[0]) begin
      discard_r    <= dat_i[`HWCF_BIT_DISCARD];
      multi_r      <= dat_i[`HWCF_BIT_MULTI];
      ee_tmo_sel_r <= dat_i[`HWCF_BIT_EE_TMO];
      burst_en_r   <= dat_i[`HWCF_BIT_BURST_EN];
    end
  end

  // The strap is caught on the first edge after reset release or after a full
  // reset request, so the reset value follows the pin level.
  // Later pin changes are seen only after the next reset release or full reset request.
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_pend_r <= 1'b1;
      phy_ext_r    <= 1'b0;
    end else if (full_req) begin
      strap_pend_r <= 1'b1;
    end else if (strap_pend_r) begin
      strap_pend_r <= 1'b0;
      phy_ext_r    <= phy_choice_pin_i; // R8
    end
  end

  // Drive boost is software writable and restored from the EEPROM image.
  // A restore wins over a write in the same cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      boost_r <= `HWCF_RST_BOOST;
    end else if (usb_bus_reset_i | lite_req | (st_r == S_LOAD && eeprom_load_done_i)) begin
      boost_r <= eeprom_present_i ? eeprom_boost_i : `HWCF_RST_BOOST; // R12
    end else if (wr_acc & hit_cfg & sel_i[1]) begin
      boost_r <= dat_i[`HWCF_BOOST_HI:`HWCF_BOOST_LO];
    end
  end
  assign hs_drive_boost_o = boost_r;

  // --------------------------------------------------------------------------
  // Soft reset sequencer
  // --------------------------------------------------------------------------
  // The hold counter is loaded on the request and runs down.
  // A full reset then waits until the EEPROM is read again.
  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        if (full_req) st_nxt = S_FULL;
        else if (lite_req) st_nxt = S_LITE;
      end
      S_LITE: begin
        if (rcnt_r == {RC_W{1'b0}}) st_nxt = S_IDLE; // R5
      end
      S_FULL: begin
        if (rcnt_r == {RC_W{1'b0}}) st_nxt = S_LOAD;
      end
      S_LOAD: begin
        if (eeprom_load_done_i) st_nxt = S_IDLE; // R11
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r     <= S_IDLE;
      rcnt_r   <= {RC_W{1'b0}};
      reload_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      // The reload strobe fires once, on the first EEPROM reload wait cycle.
      reload_r <= (st_r == S_FULL) && (rcnt_r == {RC_W{1'b0}}); // R11
      if (seq_start) rcnt_r <= RST_CYC[RC_W-1:0] - 1'b1;
      else if (rcnt_r != {RC_W{1'b0}}) rcnt_r <= rcnt_r - 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Reset outputs
  // --------------------------------------------------------------------------
  // Lite reset holds only the core; the device controller, the EEPROM and
  // the USB PHY connection stay as they are.
  assign core_rst_o       = lite_busy | full_busy;       // R6
  assign udc_rst_o        = (st_r == S_FULL);            // R6
  assign ext_phy_rst_o    = (st_r == S_FULL) & phy_ext_r; // R10
  assign usb_phy_detach_o = full_busy;                   // R11
  assign eeprom_reload_o  = reload_r;                    // R11

  // --------------------------------------------------------------------------
  // EEPROM response timer
  // --------------------------------------------------------------------------
  assign tmo_lim = ee_tmo_sel_r ? EE_SHORT_CYC[TMO_W-1:0] : EE_LONG_CYC[TMO_W-1:0]; // R4

  // The count restarts whenever the controller stops waiting; the time-out
  // is a single pulse when the wait reaches the selected limit.
  // A select change during a wait applies at once unless the count has passed the new limit; then it runs on until it wraps.
  always @(posedge clk_i) begin
    if (rst_i) begin
      tmo_cnt_r <= {TMO_W{1'b0}};
      tmo_r     <= 1'b0;
    end else begin
      tmo_r <= 1'b0;
      if (!ee_wait_i) begin
        tmo_cnt_r <= {TMO_W{1'b0}};
      end else if (tmo_cnt_r != tmo_lim) begin
        tmo_cnt_r <= tmo_cnt_r + 1'b1;
        if (tmo_cnt_r + 1'b1 == tmo_lim) tmo_r <= 1'b1; // R4
      end
    end
  end
  assign ee_timeout_o = tmo_r;

  // --------------------------------------------------------------------------
  // Transmit controls
  // --------------------------------------------------------------------------
  // An all-ones limit means no cap applies.
  // Packed frames are always accepted on receive.
  always @(posedge clk_i) begin
    if (rst_i) limit_r <= {CAP_W{1'b1}};
    else limit_r <= burst_en_r ? burst_cap_i : {CAP_W{1'b1}}; // R9
  end
  assign tx_burst_limit_o  = limit_r;
  assign tx_multi_frame_o  = multi_r; // R2
  assign usb_rx_multi_ok_o = 1'b1;    // R3

  // --------------------------------------------------------------------------
  // Received frame path
  // --------------------------------------------------------------------------
  // Errored frames are swallowed here when discard is on and never reach the
  // buffer; otherwise they pass like any other frame.
  assign drop        = rxd_err_i & discard_r; // R1
  assign in_valid    = rxd_valid_i & ~drop & ~core_rst_o;
  // A soft reset refuses every descriptor, errored ones too.
  assign rxd_ready_o = ~core_rst_o & (drop | in_ready);
  assign in_push     = in_valid & in_ready;

  // Any soft reset empties the buffer along with the level.
  hwcf_buf #(
    .W (LEN_W)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i | core_rst_o),
    .in_valid_i  (in_valid),
    .in_ready_o  (in_ready),
    .in_data_i   (rxd_len_i),
    .out_valid_o (fifo_valid_o),
    .out_ready_i (fifo_ready_i),
    .out_data_o  (fifo_len_o),
    .full_o      (),
    .empty_o     ()
  );

  // --------------------------------------------------------------------------
  // Receive FIFO level
  // --------------------------------------------------------------------------
  // Each frame adds its length rounded up to a dword; each dword read by the
  // USB receive side takes four bytes away.
  // The floor stops a stray read pulse from wrapping.
  // A frame taken with a read in one cycle still counts.
  assign rounded = {{(16-LEN_W){1'b0}}, rxd_len_i[LEN_W-1:2], 2'b00} +
                   {13'h0000, |rxd_len_i[1:0], 2'b00}; // R13

  always @* begin
    level_nxt = level_r;
    if (in_push) level_nxt = level_nxt + rounded;
    if (fifo_dword_read_i && level_r >= 16'h0004) level_nxt = level_nxt - 16'h0004;
  end

  always @(posedge clk_i) begin
    if (rst_i | core_rst_o) level_r <= `HWCF_RST_RX_LEVEL; // R13
    else level_r <= level_nxt;
  end

endmodule

// *** testbench/hwcf_asserts.sv ***
// Concurrent checks on the ports of the configuration and receive level block.
`timescale 1ns/1ps
module hwcf_asserts #(
  parameter LEN_W = 14
) (
  // Clock and reset
  input logic             clk_i,
  input logic             rst_i,
  // Register bus
  input logic             cyc_i,
  input logic             stb_i,
  input logic             ack_o,
  // EEPROM timer
  input logic             ee_wait_i,
  input logic             ee_timeout_o,
  // Descriptor path
  input logic             rxd_valid_i,
  input logic             rxd_ready_o,
  input logic             rxd_err_i,
  input logic             fifo_valid_o,
  input logic             fifo_ready_i,
  input logic [LEN_W-1:0] fifo_len_o,
  // Reset controls
  input logic             core_rst_o,
  input logic             udc_rst_o,
  input logic             ext_phy_rst_o,
  input logic             usb_phy_detach_o,
  input logic             eeprom_reload_o,
  input logic             usb_rx_multi_ok_o
);
  logic [15:0] wait_cnt_r;

  // ----------------------------------------------------------------------
  // Helper counter of consecutive EEPROM wait cycles
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i || !ee_wait_i) begin
      wait_cnt_r <= 16'h0000;
    end else if (wait_cnt_r != 16'hffff) begin
      wait_cnt_r <= wait_cnt_r + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence

  AST_WB_ACK: assert property (s_req |=> s_ack)
    else $error("bus access not acknowledged for exactly one cycle");
  AST_RX_MULTI: assert property (usb_rx_multi_ok_o)
    else $error("receive side refuses packed frames");
  AST_UDC_DETACH: assert property (udc_rst_o |-> usb_phy_detach_o && core_rst_o)
    else $error("device controller reset without detach");
  AST_EXT_PHY: assert property (ext_phy_rst_o |-> udc_rst_o)
    else $error("external PHY reset outside full reset");
  AST_RELOAD: assert property (eeprom_reload_o |-> usb_phy_detach_o ##1 !eeprom_reload_o)
    else $error("EEPROM reload while attached or too long");
  AST_CORE_LEN: assert property ($rose(core_rst_o) |-> core_rst_o [*4])
    else $error("soft reset shorter than its hold time");
  AST_PASS: assert property (rxd_valid_i && rxd_ready_o && !rxd_err_i |=> fifo_valid_o)
    else $error("good frame not passed on");
  AST_HOLD: assert property (fifo_valid_o && !fifo_ready_i && !core_rst_o |=> fifo_valid_o && $stable(fifo_len_o))
    else $error("stalled descriptor changed or lost");
  AST_REFUSE: assert property (core_rst_o |-> !rxd_ready_o)
    else $error("descriptor accepted during reset");
  AST_EE_TMO: assert property (ee_timeout_o |-> wait_cnt_r >= 16'h0040)
    else $error("EEPROM time-out too early");
endmodule

bind hwcf_top hwcf_asserts #(.LEN_W(LEN_W)) hwcf_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .ee_wait_i(ee_wait_i),
  .ee_timeout_o(ee_timeout_o), .rxd_valid_i(rxd_valid_i), .rxd_ready_o(rxd_ready_o), .rxd_err_i(rxd_err_i),
  .fifo_valid_o(fifo_valid_o), .fifo_ready_i(fifo_ready_i), .fifo_len_o(fifo_len_o), .core_rst_o(core_rst_o),
  .udc_rst_o(udc_rst_o), .ext_phy_rst_o(ext_phy_rst_o), .usb_phy_detach_o(usb_phy_detach_o),
  .eeprom_reload_o(eeprom_reload_o), .usb_rx_multi_ok_o(usb_rx_multi_ok_o));

// *** testbench/hwcf_sink.sv ***
// Receive FIFO writer model that takes descriptors and can stall.
`timescale 1ns/1ps
module hwcf_sink #(
  parameter LEN_W = 14
) (
  // Clock and reset
  input  logic             clk_i,
  input  logic             rst_i,
  // Descriptor stream
  input  logic             valid_i,
  output logic             ready_o,
  input  logic [LEN_W-1:0] len_i,
  // Control and observation
  input  logic             stall_i,
  output logic [LEN_W-1:0] last_len_o,
  output logic [7:0]       count_o
);
  assign ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 8'h00;
      last_len_o <= '0;
    end else if (valid_i && ready_o) begin
      count_o <= count_o + 8'h01;
      last_len_o <= len_i;
    end
  end
endmodule

// *** testbench/test_hw_config_and_rx_fifo_level.sv ***
// Self-checking bench for the configuration register and receive level block.
`timescale 1ns/1ps
module test_hw_config_and_rx_fifo_level;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [11:0] adr_i = '0;
  logic [3:0]  sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, q;
  logic        ack_o, load_done = 1'b0, usb_rst = 1'b0, ee_wait = 1'b0, ee_tmo;
  logic        rv = 1'b0, rerr = 1'b0, rr, fv, fr, drain = 1'b0, stall = 1'b0;
  logic [13:0] rlen = '0, flen, slen;
  logic [7:0]  scnt, lim;
  logic [1:0]  boost;
  logic        multi, usb_device_controller, xrst, det, reload, crst, psel = 1'b1;
  int          fail_count = 0, checks_done = 0;

  always #10 clk_i = ~clk_i;

  hwcf_top #(.RST_CYC(4), .EE_LONG_CYC(200)) hwcf_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .phy_choice_pin_i(psel), .eeprom_present_i(1'b1),
    .eeprom_boost_i(2'b01), .eeprom_load_done_i(load_done), .usb_bus_reset_i(usb_rst), .ee_wait_i(ee_wait),
    .ee_timeout_o(ee_tmo), .rxd_valid_i(rv), .rxd_ready_o(rr), .rxd_len_i(rlen), .rxd_err_i(rerr),
    .fifo_valid_o(fv), .fifo_ready_i(fr), .fifo_len_o(flen), .fifo_dword_read_i(drain),
    .burst_cap_i(8'h5a), .tx_burst_limit_o(lim), .tx_multi_frame_o(multi), .usb_rx_multi_ok_o(),
    .core_rst_o(crst), .udc_rst_o(usb_device_controller), .ext_phy_rst_o(xrst), .usb_phy_detach_o(det),
    .eeprom_reload_o(reload), .hs_drive_boost_o(boost));

  hwcf_sink hwcf_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .valid_i(fv), .ready_o(fr), .len_i(flen),
    .stall_i(stall), .last_len_o(slen), .count_o(scnt));

  task automatic conclude;
    $display("Checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    fail_count++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) fail($sformatf("value %h, expected %h", g, e));
  endtask
  task automatic chkb(input logic g, input logic e);
    checks_done++;
    if (g !== e) fail("flag differs");
  endtask

  // ----------------------------------------------------------------------
  // Bus and stream drivers
  // ----------------------------------------------------------------------
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin fail("no bus answer"); conclude(); end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(q, e);
  endtask
  task automatic send(input logic [13:0] len, input logic e);
    int n = 0;
    rv <= 1'b1;
    rlen <= len;
    rerr <= e;
    do begin @(posedge clk_i); n++; end while (rr !== 1'b1 && n < 50);
    if (n >= 50) begin fail("descriptor stuck"); conclude(); end
    rv <= 1'b0;
    @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd(12'h018, 32'h0000_0000);
    rd(12'h014, 32'h0000_0004);
    wb(1'b1, 12'h018, 32'h0000_ffff);
    rd(12'h018, 32'h0000_0000);
    wb(1'b1, 12'h100, 32'h0000_ffff);
    rd(12'h100, 32'h0000_0000);
    rd(12'h014, 32'h0000_0004);
  endtask
  task automatic t_cfg;
    wb(1'b1, 12'h014, 32'h0000_6072);
    rd(12'h014, 32'h0000_6076);
    repeat (2) @(posedge clk_i);
    chkb(multi, 1'b1);
    chk(32'(lim), 32'h0000_005a);
    wb(1'b1, 12'h014, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chkb(multi, 1'b0);
    chk(32'(lim), 32'h0000_00ff);
  endtask
  task automatic t_rx;
    wb(1'b1, 12'h014, 32'h0000_0040);
    send(14'h0007, 1'b1);
    stall <= 1'b1;
    send(14'h0005, 1'b0);
    send(14'h0008, 1'b0);
    rv <= 1'b1;
    rlen <= 14'h0001;
    repeat (3) @(posedge clk_i);
    chkb(rr, 1'b0);
    stall <= 1'b0;
    send(14'h0001, 1'b0);
    repeat (3) @(posedge clk_i);
    chk(32'(scnt), 32'h0000_0003);
    chk(32'(slen), 32'h0000_0001);
    rd(12'h018, 32'h0000_0014);
    wb(1'b1, 12'h014, 32'h0000_0000);
    send(14'h0003, 1'b1);
    repeat (3) @(posedge clk_i);
    chk(32'(scnt), 32'h0000_0004);
    repeat (2) begin
      drain <= 1'b1;
      @(posedge clk_i);
      drain <= 1'b0;
      @(posedge clk_i);
    end
    rd(12'h018, 32'h0000_0010);
  endtask
  task automatic t_ee;
    int n;
    int lc;
    for (int k = 0; k < 2; k++) begin
      lc = (k == 0) ? 64 : 200;
      wb(1'b1, 12'h014, (k == 0) ? 32'h0000_0010 : 32'h0000_0000);
      ee_wait <= 1'b1;
      n = 0;
      do begin @(posedge clk_i); n++; end while (ee_tmo !== 1'b1 && n < 400);
      ee_wait <= 1'b0;
      chkb(n >= lc && n <= lc + 3, 1'b1);
      @(posedge clk_i);
    end
  endtask
  task automatic t_lite;
    int n = 0;
    wb(1'b1, 12'h014, 32'h0000_6008);
    chkb(crst, 1'b1);
    wb(1'b0, 12'h014, '0);
    chkb(q[3], 1'b1);
    do begin
      chkb(usb_device_controller | det | reload, 1'b0);
      wb(1'b0, 12'h014, '0);
      n++;
    end while (q[3] !== 1'b0 && n < 20);
    chk(q, 32'h0000_2004);
    chkb(crst, 1'b0);
    wb(1'b1, 12'h014, 32'h0000_6000);
    usb_rst <= 1'b1;
    @(posedge clk_i);
    usb_rst <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(boost), 32'h0000_0001);
  endtask
  task automatic t_full;
    int n = 0;
    logic seen = 1'b0;
    wb(1'b1, 12'h014, 32'h0000_0001);
    @(posedge clk_i);
    while (reload !== 1'b1 && n < 50) begin
      chkb(det, 1'b1);
      seen = seen | (xrst === 1'b1);
      @(posedge clk_i);
      n++;
    end
    chkb(seen, 1'b1);
    chkb(reload, 1'b1);
    repeat (3) @(posedge clk_i);
    chkb(det, 1'b1);
    wb(1'b0, 12'h014, '0);
    chkb(q[0], 1'b1);
    load_done <= 1'b1;
    @(posedge clk_i);
    load_done <= 1'b0;
    repeat (3) @(posedge clk_i);
    chkb(det, 1'b0);
    rd(12'h014, 32'h0000_2004);
    psel <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(12'h014, 32'h0000_0000);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_cfg();
    t_rx();
    t_ee();
    t_lite();
    t_full();
    conclude();
  end
endmodule
